// *** core/mssx_regs.svh ***
// mssx_regs.svh: register offsets, reset values and fixed constants of the executor
// assumes: included by bare name from the package and the design files
`ifndef MSSX_REGS_SVH
`define MSSX_REGS_SVH

`define MSSX_REG_ACC 4'h0
`define MSSX_REG_STATUS 4'h1
`define MSSX_REG_TPTR_LO 4'h2
`define MSSX_REG_TPTR_HI 4'h3
`define MSSX_REG_TLATCH 4'h4
`define MSSX_REG_DMPTR 4'h5
`define MSSX_REG_DMDATA 4'h6
`define MSSX_REG_SKIPCNT 4'h7
`define MSSX_REG_STATE 4'h8

`define MSSX_BYTE_ZERO 8'h00
`define MSSX_BYTE_ONE 8'h01
`define MSSX_BYTE_ONES 8'hFF
`define MSSX_LAST_PAGE 8'hFF
`define MSSX_WORD_ZERO 16'h0000
`define MSSX_FLAGS_W 4
`define MSSX_FLAGS_RST 4'h0
`define MSSX_STATUS_PAD 4'h0
`define MSSX_DMEM_DEPTH 64
`define MSSX_DMEM_AW 6
`define MSSX_DADDR_ZERO 6'h00

`endif

// *** core/mssx_pkg.sv ***
// mssx_pkg.sv: types and shared helper functions of the instruction executor
// assumes: mssx_regs.svh sits on the include path
`include "mssx_regs.svh"
package mssx_pkg;
  typedef logic [7:0] mssx_byte_t;
  typedef logic [15:0] mssx_word_t;
  typedef logic [3:0] mssx_raddr_t;
  typedef logic [2:0] mssx_bitsel_t;
  typedef logic [`MSSX_DMEM_AW-1:0] mssx_daddr_t;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_DEC_SKIP_TO_ACC = 5'h01,
    OP_SET_BYTE = 5'h02,
    OP_SET_BIT = 5'h03,
    OP_INC_SKIP_ZERO = 5'h04,
    OP_INC_SKIP_TO_ACC = 5'h05,
    OP_BIT_ONE_SKIP = 5'h06,
    OP_SUB_ACC_MEM = 5'h07,
    OP_MINUS_TO_MEMORY = 5'h08,
    OP_SUB_IMM = 5'h09,
    OP_NIBBLE_SWAP = 5'h0A,
    OP_NIBBLE_EXCHANGE_TO_ACC = 5'h0B,
    OP_ZERO_TEST_SKIP = 5'h0C,
    OP_ZERO_COPY_SKIP = 5'h0D,
    OP_BIT_ZERO_SKIP = 5'h0E,
    OP_TABLE_FETCH_PAGED = 5'h0F,
    OP_TABLE_FETCH_CURRENT = 5'h10,
    OP_TABLE_FETCH_FINAL = 5'h11,
    OP_XOR_ACC_MEM = 5'h12,
    OP_EXCLUSIVE_OR_TO_MEMORY = 5'h13,
    OP_XOR_IMM = 5'h14
  } mssx_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DUMMY = 4'b0010,
    ST_TAB_REQ = 4'b0100,
    ST_TAB_DATA = 4'b1000
  } mssx_state_t;

  typedef struct packed {
    logic signed_range_flag;
    logic nibble_borrow_flag;
    logic c;
    logic z;
  } mssx_flags_t;

  typedef struct packed {
    mssx_op_t op;
    mssx_daddr_t addr;
    mssx_bitsel_t bitsel;
    mssx_byte_t imm;
  } mssx_instr_t;

  typedef struct packed {
    mssx_byte_t diff;
    mssx_flags_t flags;
  } mssx_sub_t;

  function automatic logic mssx_is_zero(input mssx_byte_t b);
    return b == `MSSX_BYTE_ZERO;
  endfunction

  function automatic mssx_byte_t mssx_swap_nib(input mssx_byte_t b);
    return {b[3:0], b[7:4]};
  endfunction

  function automatic logic mssx_bit_of(input mssx_byte_t b, input mssx_bitsel_t sel);
    return b[sel];
  endfunction
endpackage

// *** core/mssx_sub.sv ***
// mssx_sub.sv: eight-bit subtractor producing difference and arithmetic flags
// assumes: purely combinational, operands from the executor's clock domain
`include "mssx_regs.svh"
module mssx_sub
(
  input wire mssx_pkg::mssx_byte_t a_in,
  input wire mssx_pkg::mssx_byte_t b_in,
  output mssx_pkg::mssx_sub_t res_out
);
  import mssx_pkg::*;

  mssx_byte_t diff;

  always_comb
  begin
    diff = a_in - b_in;
    res_out.diff = diff;
    // carry and nibble flag read as "no borrow"
    res_out.flags.c = a_in >= b_in;
    res_out.flags.nibble_borrow_flag = a_in[3:0] >= b_in[3:0];
    res_out.flags.signed_range_flag = (a_in[7] ^ b_in[7]) & (diff[7] ^ a_in[7]);
    res_out.flags.z = mssx_is_zero(diff);
  end
endmodule

// *** core/mssx_dmem.sv ***
// mssx_dmem.sv: flip-flop data memory, two combinational read ports, one write port
// assumes: writer resolves its own conflicts; reads see the value before the edge
`include "mssx_regs.svh"
module mssx_dmem
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire mssx_pkg::mssx_daddr_t rd_a_idx_in,
  output mssx_pkg::mssx_byte_t rd_a_data_out,
  input wire mssx_pkg::mssx_daddr_t rd_b_idx_in,
  output mssx_pkg::mssx_byte_t rd_b_data_out,
  input wire logic wr_en_in,
  input wire mssx_pkg::mssx_daddr_t wr_idx_in,
  input wire mssx_pkg::mssx_byte_t wr_data_in
);
  import mssx_pkg::*;

  mssx_byte_t mem_r [`MSSX_DMEM_DEPTH];
  mssx_byte_t mem_nxt [`MSSX_DMEM_DEPTH];

  assign rd_a_data_out = mem_r[rd_a_idx_in];
  assign rd_b_data_out = mem_r[rd_b_idx_in];

  always_comb
  begin
    mem_nxt = mem_r;
    if (wr_en_in)
    begin
      mem_nxt[wr_idx_in] = wr_data_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < `MSSX_DMEM_DEPTH; i++)
      begin
        mem_r[i] <= `MSSX_BYTE_ZERO;
      end
    end
    else
    begin
      mem_r <= mem_nxt;
    end
  end
endmodule

// *** core/mssx_core.sv ***
// mssx_core.sv: executes skip, set, subtract, swap, table read and xor instructions
// assumes: issuer on clk_in holds back while busy_out is high; program memory
// returns prog_data_in in the cycle after prog_rd_out is high
// Summary of operation
// - dec-skip-to-acc: acc gets memory minus one, memory kept, skip on zero, no flags.
// - taken skip adds one dummy cycle; untaken skip continues normally.
// - set-byte writes all ones to memory, flags untouched.
// - set-bit forces the selected bit to one, other bits and flags kept.
// - inc-skip writes memory plus one back, skips when that is zero.
// - inc-skip-to-acc: acc gets memory plus one, memory kept, skip on zero.
// - bit-one skip skips when the selected bit is one, nothing modified.
// - acc minus memory into acc, updates all four flags, carry means no borrow.
// - same subtraction, result written to memory instead of acc.
// - acc minus immediate into acc, same four flags.
// - nibble swap exchanges memory nibbles in place, no flags.
// - nibble exchange to acc: swapped memory into acc, memory kept.
// - zero-test skip skips when the memory byte is zero, nothing modified.
// - zero-copy skip copies memory into acc, skips when zero, no flags.
// - bit-zero skip skips when the selected bit is zero.
// - paged table read uses both pointers; low byte to memory, high to latch.
// - current-page table read uses current page and low pointer.
// - final-page table read uses last page and low pointer, no flags.
// - xor memory into acc, only zero flag changes.
// - xor result written back to memory, only zero flag changes.
// - xor immediate into acc, only zero flag changes.
//
// Strobed register access and the register addresses were decided locally.
`include "mssx_regs.svh"
module mssx_core
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic instr_valid_in,
  input wire mssx_pkg::mssx_instr_t instr_in,
  input wire mssx_pkg::mssx_byte_t page_in,
  input wire mssx_pkg::mssx_word_t prog_data_in,
  output mssx_pkg::mssx_word_t prog_addr_out,
  output logic prog_rd_out,
  output logic busy_out,
  output logic skip_out,
  output mssx_pkg::mssx_byte_t acc_out,
  output mssx_pkg::mssx_flags_t flags_out,
  output mssx_pkg::mssx_byte_t table_high_byte_latch_out,
  input wire mssx_pkg::mssx_raddr_t reg_addr_in,
  input wire mssx_pkg::mssx_byte_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output mssx_pkg::mssx_byte_t reg_rdata_out
);
  import mssx_pkg::*;

  mssx_state_t state_r, state_nxt;
  mssx_byte_t acc_r, acc_nxt;
  mssx_flags_t flags_r, flags_nxt;
  mssx_byte_t table_pointer_low_r, table_pointer_low_nxt;
  mssx_byte_t table_pointer_high_r, table_pointer_high_nxt;
  mssx_byte_t tab_latch_r, tab_latch_nxt;
  mssx_daddr_t dm_ptr_r, dm_ptr_nxt;
  mssx_daddr_t tab_idx_r, tab_idx_nxt;
  mssx_word_t prog_addr_r, prog_addr_nxt;
  logic prog_rd_r, prog_rd_nxt;
  logic busy_r, busy_nxt;
  logic skip_r, skip_nxt;
  mssx_byte_t skip_cnt_r, skip_cnt_nxt;
  mssx_byte_t rdata_r, rdata_nxt;

  logic exec;
  logic skip_take;
  logic tab_start;
  mssx_word_t tab_addr;
  logic ex_we;
  mssx_byte_t ex_val;
  logic dm_we;
  mssx_daddr_t dm_idx;
  mssx_byte_t dm_data;
  mssx_byte_t mem_val, sw_mem_val;
  mssx_byte_t dec_val, inc_val, swap_val, xor_m, xor_i, sub_b, prog_hi;
  mssx_sub_t sub_res;

  assign exec = instr_valid_in && (state_r == ST_IDLE);
  assign dec_val = mem_val - `MSSX_BYTE_ONE;
  assign inc_val = mem_val + `MSSX_BYTE_ONE;
  assign swap_val = mssx_swap_nib(mem_val);
  assign xor_m = acc_r ^ mem_val;
  assign xor_i = acc_r ^ instr_in.imm;
  assign sub_b = (instr_in.op == OP_SUB_IMM) ? instr_in.imm : mem_val;
  assign prog_hi = prog_data_in[15:8];

  mssx_dmem u_dmem
  (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .rd_a_idx_in(instr_in.addr),
    .rd_a_data_out(mem_val),
    .rd_b_idx_in(dm_ptr_r),
    .rd_b_data_out(sw_mem_val),
    .wr_en_in(dm_we),
    .wr_idx_in(dm_idx),
    .wr_data_in(dm_data)
  );

  mssx_sub u_sub
  (
    .a_in(acc_r),
    .b_in(sub_b),
    .res_out(sub_res)
  );

  always_comb
  begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    table_pointer_low_nxt = table_pointer_low_r;
    table_pointer_high_nxt = table_pointer_high_r;
    tab_latch_nxt = tab_latch_r;
    dm_ptr_nxt = dm_ptr_r;
    tab_idx_nxt = tab_idx_r;
    skip_cnt_nxt = skip_cnt_r;
    rdata_nxt = `MSSX_BYTE_ZERO;
    skip_take = 1'b0;
    tab_start = 1'b0;
    tab_addr = prog_addr_r;
    ex_we = 1'b0;
    ex_val = mem_val;
    dm_we = 1'b0;
    dm_idx = instr_in.addr;
    dm_data = mem_val;
    // software goes first; an instruction in the same cycle overrides it
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        `MSSX_REG_ACC: acc_nxt = reg_wdata_in;
        `MSSX_REG_STATUS: flags_nxt = mssx_flags_t'(reg_wdata_in[`MSSX_FLAGS_W-1:0]);
        `MSSX_REG_TPTR_LO: table_pointer_low_nxt = reg_wdata_in;
        `MSSX_REG_TPTR_HI: table_pointer_high_nxt = reg_wdata_in;
        `MSSX_REG_DMPTR: dm_ptr_nxt = reg_wdata_in[`MSSX_DMEM_AW-1:0];
        `MSSX_REG_DMDATA:
        begin
          dm_we = 1'b1;
          dm_idx = dm_ptr_r;
          dm_data = reg_wdata_in;
        end
        default: ;
      endcase
    end
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `MSSX_REG_ACC: rdata_nxt = acc_r;
        `MSSX_REG_STATUS: rdata_nxt = {`MSSX_STATUS_PAD, flags_r};
        `MSSX_REG_TPTR_LO: rdata_nxt = table_pointer_low_r;
        `MSSX_REG_TPTR_HI: rdata_nxt = table_pointer_high_r;
        `MSSX_REG_TLATCH: rdata_nxt = tab_latch_r;
        `MSSX_REG_DMPTR: rdata_nxt = 8'(dm_ptr_r);
        `MSSX_REG_DMDATA: rdata_nxt = sw_mem_val;
        `MSSX_REG_SKIPCNT: rdata_nxt = skip_cnt_r;
        `MSSX_REG_STATE: rdata_nxt = 8'(state_r);
        default: rdata_nxt = `MSSX_BYTE_ZERO;
      endcase
    end
    if (exec)
    begin
      case (instr_in.op)
        OP_DEC_SKIP_TO_ACC:
        begin
          acc_nxt = dec_val;
          skip_take = mssx_is_zero(dec_val);
        end
        OP_SET_BYTE:
        begin
          ex_we = 1'b1;
          ex_val = `MSSX_BYTE_ONES;
        end
        OP_SET_BIT:
        begin
          ex_we = 1'b1;
          ex_val = mem_val | (`MSSX_BYTE_ONE << instr_in.bitsel);
        end
        OP_INC_SKIP_ZERO:
        begin
          ex_we = 1'b1;
          ex_val = inc_val;
          skip_take = mssx_is_zero(inc_val);
        end
        OP_INC_SKIP_TO_ACC:
        begin
          acc_nxt = inc_val;
          skip_take = mssx_is_zero(inc_val);
        end
        OP_BIT_ONE_SKIP: skip_take = mssx_bit_of(mem_val, instr_in.bitsel);
        OP_SUB_ACC_MEM:
        begin
          acc_nxt = sub_res.diff;
          flags_nxt = sub_res.flags;
        end
        OP_MINUS_TO_MEMORY:
        begin
          ex_we = 1'b1;
          ex_val = sub_res.diff;
          flags_nxt = sub_res.flags;
        end
        OP_SUB_IMM:
        begin
          acc_nxt = sub_res.diff;
          flags_nxt = sub_res.flags;
        end
        OP_NIBBLE_SWAP:
        begin
          ex_we = 1'b1;
          ex_val = swap_val;
        end
        OP_NIBBLE_EXCHANGE_TO_ACC: acc_nxt = swap_val;
        OP_ZERO_TEST_SKIP: skip_take = mssx_is_zero(mem_val);
        OP_ZERO_COPY_SKIP:
        begin
          acc_nxt = mem_val;
          skip_take = mssx_is_zero(mem_val);
        end
        OP_BIT_ZERO_SKIP: skip_take = !mssx_bit_of(mem_val, instr_in.bitsel);
        OP_TABLE_FETCH_PAGED:
        begin
          tab_start = 1'b1;
          tab_addr = {table_pointer_high_r, table_pointer_low_r};
        end
        OP_TABLE_FETCH_CURRENT:
        begin
          tab_start = 1'b1;
          tab_addr = {page_in, table_pointer_low_r};
        end
        OP_TABLE_FETCH_FINAL:
        begin
          tab_start = 1'b1;
          tab_addr = {`MSSX_LAST_PAGE, table_pointer_low_r};
        end
        OP_XOR_ACC_MEM:
        begin
          acc_nxt = xor_m;
          flags_nxt.z = mssx_is_zero(xor_m);
        end
        OP_EXCLUSIVE_OR_TO_MEMORY:
        begin
          ex_we = 1'b1;
          ex_val = xor_m;
          flags_nxt.z = mssx_is_zero(xor_m);
        end
        OP_XOR_IMM:
        begin
          acc_nxt = xor_i;
          flags_nxt.z = mssx_is_zero(xor_i);
        end
        default: ;
      endcase
    end
    // a same-cycle software memory write is dropped in favour of the instruction
    if (ex_we)
    begin
      dm_we = 1'b1;
      dm_idx = instr_in.addr;
      dm_data = ex_val;
    end
    case (state_r)
      ST_IDLE:
      begin
        if (skip_take)
        begin
          state_nxt = ST_DUMMY;
          skip_cnt_nxt = skip_cnt_r + `MSSX_BYTE_ONE;
        end
        else if (tab_start)
        begin
          state_nxt = ST_TAB_REQ;
          tab_idx_nxt = instr_in.addr;
        end
      end
      ST_DUMMY: state_nxt = ST_IDLE;
      ST_TAB_REQ: state_nxt = ST_TAB_DATA;
      ST_TAB_DATA:
      begin
        state_nxt = ST_IDLE;
        dm_we = 1'b1;
        dm_idx = tab_idx_r;
        dm_data = prog_data_in[7:0];
        tab_latch_nxt = prog_hi;
      end
      default: state_nxt = ST_IDLE;
    endcase
    prog_addr_nxt = tab_start ? tab_addr : prog_addr_r;
    prog_rd_nxt = state_nxt == ST_TAB_REQ;
    busy_nxt = state_nxt != ST_IDLE;
    skip_nxt = state_nxt == ST_DUMMY;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      state_r <= ST_IDLE;
      acc_r <= `MSSX_BYTE_ZERO;
      flags_r <= mssx_flags_t'(`MSSX_FLAGS_RST);
      table_pointer_low_r <= `MSSX_BYTE_ZERO;
      table_pointer_high_r <= `MSSX_BYTE_ZERO;
      tab_latch_r <= `MSSX_BYTE_ZERO;
      dm_ptr_r <= `MSSX_DADDR_ZERO;
      tab_idx_r <= `MSSX_DADDR_ZERO;
      prog_addr_r <= `MSSX_WORD_ZERO;
      prog_rd_r <= 1'b0;
      busy_r <= 1'b0;
      skip_r <= 1'b0;
      skip_cnt_r <= `MSSX_BYTE_ZERO;
      rdata_r <= `MSSX_BYTE_ZERO;
    end
    else
    begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
      table_pointer_low_r <= table_pointer_low_nxt;
      table_pointer_high_r <= table_pointer_high_nxt;
      tab_latch_r <= tab_latch_nxt;
      dm_ptr_r <= dm_ptr_nxt;
      tab_idx_r <= tab_idx_nxt;
      prog_addr_r <= prog_addr_nxt;
      prog_rd_r <= prog_rd_nxt;
      busy_r <= busy_nxt;
      skip_r <= skip_nxt;
      skip_cnt_r <= skip_cnt_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign prog_addr_out = prog_addr_r;
  assign prog_rd_out = prog_rd_r;
  assign busy_out = busy_r;
  assign skip_out = skip_r;
  assign acc_out = acc_r;
  assign flags_out = flags_r;
  assign table_high_byte_latch_out = tab_latch_r;
  assign reg_rdata_out = rdata_r;

  // checks gated by quiet ignore cycles where software also writes, since it may alter acc or flags
  logic quiet;
  assign quiet = exec && !reg_wr_in;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_skip_exec;
    exec && skip_take;
  endsequence

  sequence s_dummy_slot;
    (busy_out && skip_out) ##1 (!busy_out && !skip_out);
  endsequence

  sequence s_tab_exec;
    exec && tab_start;
  endsequence

  sequence s_tab_walk;
    (prog_rd_out && busy_out) ##1 (!prog_rd_out && busy_out) ##1 !busy_out;
  endsequence

  a_skip_dummy: assert property (s_skip_exec |=> s_dummy_slot)
    else $error("taken skip did not give exactly one dummy cycle");
  a_noskip_free: assert property (exec && !skip_take && !tab_start |=> !busy_out)
    else $error("untaken skip stalled the next instruction");
  a_dec_acc: assert property (quiet && instr_in.op == OP_DEC_SKIP_TO_ACC
    |=> acc_out == $past(dec_val) && flags_out == $past(flags_out)
    && skip_out == ($past(dec_val) == `MSSX_BYTE_ZERO))
    else $error("decrement to acc gave wrong value, flags or skip");
  a_inc_skip: assert property (exec && instr_in.op == OP_INC_SKIP_ZERO
    |-> dm_we && dm_data == inc_val ##1 skip_out == ($past(inc_val) == `MSSX_BYTE_ZERO))
    else $error("increment skip wrote or skipped wrongly");
  a_set_byte: assert property (quiet && instr_in.op == OP_SET_BYTE
    |-> dm_we && dm_data == `MSSX_BYTE_ONES ##1 flags_out == $past(flags_out))
    else $error("set byte did not write all ones or touched flags");
  a_sub_flags: assert property (quiet && instr_in.op == OP_SUB_ACC_MEM
    |=> acc_out == 8'($past(acc_out) - $past(mem_val))
    && flags_out.c == ($past(acc_out) >= $past(mem_val)))
    else $error("subtract gave wrong result or carry");
  a_minus_to_memory_keep: assert property (quiet && instr_in.op == OP_MINUS_TO_MEMORY
    |=> acc_out == $past(acc_out) && flags_out.c == ($past(acc_out) >= $past(mem_val)))
    else $error("subtract to memory changed acc or carry wrong");
  a_swap_acc: assert property (quiet && instr_in.op == OP_NIBBLE_EXCHANGE_TO_ACC
    |-> !dm_we ##1 acc_out == $past(swap_val))
    else $error("nibble exchange to acc wrong or memory written");
  a_xor_zero: assert property (quiet && instr_in.op == OP_XOR_ACC_MEM
    |=> flags_out.z == (acc_out == `MSSX_BYTE_ZERO) && flags_out.c == $past(flags_out.c))
    else $error("xor zero flag wrong or carry disturbed");
  a_tab_walk: assert property (s_tab_exec |=> s_tab_walk)
    else $error("table read did not walk request, data, idle");
  a_tab_latch: assert property (s_tab_exec ##2 1'b1
    |=> table_high_byte_latch_out == $past(prog_hi))
    else $error("table high byte not latched");
  a_final_page: assert property (exec && instr_in.op == OP_TABLE_FETCH_FINAL
    |=> prog_addr_out[15:8] == `MSSX_LAST_PAGE)
    else $error("final page table read used wrong page");
endmodule

// *** sim/mssx_prog_model.sv ***
// mssx_prog_model.sv: behavioural program memory that answers table reads
// assumes: one read pulse at a time, code word wanted in the following cycle only
module mssx_prog_model
(
  input wire logic clk_in,
  input wire logic rd_in,
  input wire mssx_pkg::mssx_word_t addr_in,
  output mssx_pkg::mssx_word_t data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import mssx_pkg::*;

  // word scrambles its address so that every pointer bit shows in the result
  initial data_out = 16'hA5C3;
  always @(posedge clk_in)
  begin
    if (rd_in)
      data_out <= {addr_in[7:0] ^ 8'h96, addr_in[15:8] + 8'h11};
    else
      // word holds one cycle only; toggling stops a late sample passing by luck
      data_out <= ~data_out;
  end
endmodule

// *** sim/testbench.sv ***
// testbench.sv: self-checking bench for the instruction executor
// assumes: package, core and program memory model compiled before it
`include "mssx_regs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mssx_pkg::*;

  typedef struct packed {
    mssx_op_t op;
    mssx_byte_t m, a, imm;
    mssx_flags_t f0;
    mssx_byte_t eacc, emem;
    logic esk;
    mssx_flags_t efl;
  } mssx_row_t;

  logic clk_in, rstn_in, instr_valid_in, reg_wr_in, reg_rd_in, prog_rd_out, busy_out, skip_out;
  mssx_instr_t instr_in;
  mssx_byte_t page_in, acc_out, table_high_byte_latch_out, reg_wdata_in, reg_rdata_out, v;
  mssx_word_t prog_data_in, prog_addr_out, last_addr, ea, w;
  mssx_flags_t flags_out;
  mssx_raddr_t reg_addr_in;
  mssx_daddr_t d;
  logic sk, bz;
  int failures, num_checks, nsk;
  mssx_row_t rows[$];
  mssx_op_t tops[3] = '{OP_TABLE_FETCH_PAGED, OP_TABLE_FETCH_CURRENT, OP_TABLE_FETCH_FINAL};

  mssx_core u_mssx_core (.clk_in(clk_in), .rstn_in(rstn_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .page_in(page_in), .prog_data_in(prog_data_in),
    .prog_addr_out(prog_addr_out), .prog_rd_out(prog_rd_out), .busy_out(busy_out),
    .skip_out(skip_out), .acc_out(acc_out), .flags_out(flags_out),
    .table_high_byte_latch_out(table_high_byte_latch_out), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out));
  mssx_prog_model u_mssx_prog_model (.clk_in(clk_in), .rd_in(prog_rd_out),
    .addr_in(prog_addr_out), .data_out(prog_data_in));

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
    if (prog_rd_out === 1'b1)
      last_addr <= prog_addr_out;

  task automatic end_sim();
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // every bus task leaves one idle edge so no strobe is set twice in a step
  task automatic wr(input mssx_raddr_t a, input mssx_byte_t x);
    reg_addr_in <= a;
    reg_wdata_in <= x;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input mssx_raddr_t a, output mssx_byte_t x);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 x = reg_rdata_out;
    @(posedge clk_in);
  endtask

  task automatic setm(input mssx_daddr_t a, input mssx_byte_t x);
    wr(`MSSX_REG_DMPTR, {2'h0, a});
    wr(`MSSX_REG_DMDATA, x);
  endtask

  task automatic getm(input mssx_daddr_t a, output mssx_byte_t x);
    wr(`MSSX_REG_DMPTR, {2'h0, a});
    rd(`MSSX_REG_DMDATA, x);
  endtask

  task automatic exec(input mssx_op_t op, input mssx_daddr_t a, input mssx_byte_t imm,
    output logic s, output logic b);
    int n;
    instr_in <= '{op, a, imm[2:0], imm};
    instr_valid_in <= 1'b1;
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    #1 s = skip_out;
    b = busy_out;
    n = 0;
    while (busy_out !== 1'b0 && n < 8)
    begin
      @(posedge clk_in);
      #1 n++;
    end
    @(posedge clk_in);
  endtask

  task automatic r(input mssx_op_t op, input mssx_byte_t m, a, imm, input mssx_flags_t f0,
    input mssx_byte_t ea_, em, input logic es, input mssx_flags_t ef);
    rows.push_back('{op, m, a, imm, f0, ea_, em, es, ef});
  endtask

  initial
  begin
    repeat (5000) @(posedge clk_in);
    failures++;
    end_sim();
  end

  initial
  begin
    {rstn_in, instr_valid_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    instr_in = '0;
    page_in = 8'h71;
    r(OP_DEC_SKIP_TO_ACC, 8'h1, 8'h33, 8'h0, 4'hA, 8'h0, 8'h1, 1'b1, 4'hA);
    r(OP_DEC_SKIP_TO_ACC, 8'h0, 8'h33, 8'h0, 4'h5, 8'hFF, 8'h0, 1'b0, 4'h5);
    r(OP_SET_BYTE, 8'h12, 8'h33, 8'h0, 4'hA, 8'h33, 8'hFF, 1'b0, 4'hA);
    r(OP_SET_BIT, 8'h41, 8'h33, 8'h7, 4'h5, 8'h33, 8'hC1, 1'b0, 4'h5);
    r(OP_INC_SKIP_ZERO, 8'hFF, 8'h33, 8'h0, 4'hA, 8'h33, 8'h0, 1'b1, 4'hA);
    r(OP_INC_SKIP_ZERO, 8'h7F, 8'h33, 8'h0, 4'h5, 8'h33, 8'h80, 1'b0, 4'h5);
    r(OP_INC_SKIP_TO_ACC, 8'hFF, 8'h33, 8'h0, 4'hA, 8'h0, 8'hFF, 1'b1, 4'hA);
    r(OP_INC_SKIP_TO_ACC, 8'h40, 8'h33, 8'h0, 4'h5, 8'h41, 8'h40, 1'b0, 4'h5);
    r(OP_BIT_ONE_SKIP, 8'h8, 8'h33, 8'h3, 4'hA, 8'h33, 8'h8, 1'b1, 4'hA);
    r(OP_BIT_ONE_SKIP, 8'hF7, 8'h33, 8'h3, 4'h5, 8'h33, 8'hF7, 1'b0, 4'h5);
    r(OP_SUB_ACC_MEM, 8'h20, 8'h10, 8'h0, 4'hA, 8'hF0, 8'h20, 1'b0, 4'h4);
    r(OP_SUB_ACC_MEM, 8'h1, 8'h80, 8'h0, 4'h5, 8'h7F, 8'h1, 1'b0, 4'hA);
    r(OP_MINUS_TO_MEMORY, 8'h44, 8'h44, 8'h0, 4'h8, 8'h44, 8'h0, 1'b0, 4'h7);
    r(OP_SUB_IMM, 8'h5C, 8'h5, 8'h6, 4'hF, 8'hFF, 8'h5C, 1'b0, 4'h0);
    r(OP_NIBBLE_SWAP, 8'hA5, 8'h33, 8'h0, 4'hA, 8'h33, 8'h5A, 1'b0, 4'hA);
    r(OP_NIBBLE_EXCHANGE_TO_ACC, 8'h3C, 8'h33, 8'h0, 4'h5, 8'hC3, 8'h3C, 1'b0, 4'h5);
    r(OP_ZERO_TEST_SKIP, 8'h0, 8'h33, 8'h0, 4'hA, 8'h33, 8'h0, 1'b1, 4'hA);
    r(OP_ZERO_TEST_SKIP, 8'h1, 8'h33, 8'h0, 4'h5, 8'h33, 8'h1, 1'b0, 4'h5);
    r(OP_ZERO_COPY_SKIP, 8'h0, 8'h33, 8'h0, 4'hA, 8'h0, 8'h0, 1'b1, 4'hA);
    r(OP_ZERO_COPY_SKIP, 8'h9E, 8'h33, 8'h0, 4'h5, 8'h9E, 8'h9E, 1'b0, 4'h5);
    r(OP_BIT_ZERO_SKIP, 8'hFE, 8'h33, 8'h0, 4'hA, 8'h33, 8'hFE, 1'b1, 4'hA);
    r(OP_BIT_ZERO_SKIP, 8'h1, 8'h33, 8'h0, 4'h5, 8'h33, 8'h1, 1'b0, 4'h5);
    r(OP_XOR_ACC_MEM, 8'h5A, 8'h5A, 8'h0, 4'hA, 8'h0, 8'h5A, 1'b0, 4'hB);
    r(OP_EXCLUSIVE_OR_TO_MEMORY, 8'hF0, 8'hF, 8'h0, 4'hF, 8'hF, 8'hFF, 1'b0, 4'hE);
    r(OP_XOR_IMM, 8'h5A, 8'hC3, 8'hC3, 4'h4, 8'h0, 8'h5A, 1'b0, 4'h5);
    r(OP_NOP, 8'h77, 8'h33, 8'h0, 4'h6, 8'h33, 8'h77, 1'b0, 4'h6);
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    rd(`MSSX_REG_STATE, v);
    `CHK(v, 8'h1)
    `CHK(acc_out, 8'h0)
    foreach (rows[i])
    begin
      d = mssx_daddr_t'(i + 8);
      setm(d, rows[i].m);
      wr(`MSSX_REG_ACC, rows[i].a);
      wr(`MSSX_REG_STATUS, {4'h0, rows[i].f0});
      exec(rows[i].op, d, rows[i].imm, sk, bz);
      nsk += int'(rows[i].esk);
      `CHK(sk, rows[i].esk)
      `CHK(bz, rows[i].esk)
      `CHK(acc_out, rows[i].eacc)
      `CHK(flags_out, rows[i].efl)
      getm(d, v);
      `CHK(v, rows[i].emem)
    end
    // taken skip, dropped set-byte in the dummy cycle, then set-bit accepted
    setm(6'h2, 8'h0);
    setm(6'h3, 8'h0);
    instr_in <= '{OP_ZERO_TEST_SKIP, 6'h2, 3'h0, 8'h0};
    instr_valid_in <= 1'b1;
    @(posedge clk_in);
    instr_in <= '{OP_SET_BYTE, 6'h3, 3'h0, 8'h0};
    @(posedge clk_in);
    instr_in <= '{OP_SET_BIT, 6'h3, 3'h0, 8'h0};
    @(posedge clk_in);
    instr_in <= '{OP_XOR_IMM, 6'h3, 3'h0, 8'hF0};
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    @(posedge clk_in);
    `CHK(acc_out, 8'hC3)
    getm(6'h3, v);
    `CHK(v, 8'h1)
    rd(`MSSX_REG_SKIPCNT, v);
    `CHK(v, 8'(nsk + 1))
    for (int k = 0; k < 3; k++)
    begin
      wr(`MSSX_REG_TPTR_LO, 8'h40 + 8'(k));
      wr(`MSSX_REG_TPTR_HI, 8'h2D);
      wr(`MSSX_REG_STATUS, 8'h5);
      exec(tops[k], 6'h9, 8'h0, sk, bz);
      `CHK(bz, 1'b1)
      ea = {k == 0 ? 8'h2D : (k == 1 ? 8'h71 : 8'hFF), 8'h40 + 8'(k)};
      `CHK(last_addr, ea)
      w = {ea[7:0] ^ 8'h96, ea[15:8] + 8'h11};
      `CHK(table_high_byte_latch_out, w[15:8])
      getm(6'h9, v);
      `CHK(v, w[7:0])
      `CHK(flags_out, 4'h5)
    end
    rd(4'hF, v);
    `CHK(v, 8'h0)
    wr(`MSSX_REG_TLATCH, 8'h0);
    rd(`MSSX_REG_TLATCH, v);
    `CHK(v, w[15:8])
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    `CHK(acc_out, 8'h0)
    rd(`MSSX_REG_SKIPCNT, v);
    `CHK(v, 8'h0)
    end_sim();
  end
endmodule
